/* File: verilog/ast_pkg.sv */
// constants for the asynchronous serial transmitter
package ast_pkg;
  // ****************************************************************
  // register map (word addresses on the avalon bus)
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL_STAT = 4'h0;
  localparam logic [3:0] ADDR_BAUD_DIV  = 4'h1;
  localparam logic [3:0] ADDR_HOLD_BUF  = 4'h2;
  localparam logic [3:0] ADDR_FLAGS     = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h4;
  // ****************************************************************
  // control/status, flag and irq-enable field positions
  // ****************************************************************
  localparam int CS_NINTH_DATA  = 0;
  localparam int CS_SHIFT_EMPTY = 1;
  localparam int CS_HIGH_SPEED  = 2;
  localparam int CS_SYNC_MODE   = 4;
  localparam int CS_TX_ENABLE   = 5;
  localparam int CS_NINE_BIT    = 6;
  localparam int CS_PORT_ENABLE = 7;
  localparam int FLAG_TX_EMPTY  = 4;
  localparam int IRQ_TX_EMPTY   = 4;
  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET     = 8'h02;
  localparam logic [7:0] BAUD_RESET     = 8'h00;
  localparam logic [6:0] OVERSAMPLE_HI  = 7'h10;
  localparam logic [6:0] OVERSAMPLE_LO  = 7'h40;
  localparam logic [1:0] INSTR_CYCLE    = 2'h3;
  localparam logic [3:0] BITS_8_FRAME   = 4'h9;
  localparam logic [3:0] BITS_9_FRAME   = 4'ha;
endpackage : ast_pkg

/* File: verilog/ast_baud_gen.sv */
// baud generator: divisor counter giving one-cycle oversample ticks
`timescale 1ns/10ps
module ast_baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             srst_i,
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  tick_o
);
  logic [DIV_W-1:0] count_reg;

  // ****************************************************************
  // tick every divisor+1 clocks
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !run_i)
    begin
      count_reg <= '0;
      tick_o    <= 1'b0;
    end
    else if (count_reg >= divisor_i)
    begin
      count_reg <= '0;
      tick_o    <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 1'b1;
      tick_o    <= 1'b0;
    end
  end
endmodule : ast_baud_gen

/* File: verilog/ast_transmitter.sv */
// asynchronous serial transmitter with avalon-mm register slave
`timescale 1ns/10ps
// Function
// - frame is start bit, eight or nine data bits, one stop bit.
// - baud timing comes from an eight-bit divisor counter.
// - data bits leave least significant bit first.
// - oversample is sixteen per bit when high-speed set, else sixty-four.
// - no parity; software may put it into the ninth bit.
// - sleep halts asynchronous operation.
// - asynchronous only while the synchronous-mode bit is clear.
// - shift register reloads only after the stop bit completes.
// - buffer-to-shifter move takes one instruction cycle, then empty flag sets.
// - buffer-empty raises interrupt request only while its enable is set.
// - empty flag ignores its enable; only a buffer load clears it.
// - read-only shift-empty status bit, polled, no interrupt.
// - shift register is not visible to software.
// - setting transmit enable also sets the empty flag.
// - nine-bit select sends the ninth data bit field.
// - a buffer write starts transmission when transmit is enabled.
// - empty flag becomes valid two instruction cycles after a buffer write.
module ast_transmitter #(
  parameter int DIV_W = 8
) (
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        sleep_i,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             tx_o,
  output logic             tx_irq_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT} ast_state_t;

  ast_state_t       state_reg;
  logic [7:0]       ctrl_reg;
  logic [7:0]       baud_divisor_reg;
  logic [7:0]       tx_holding_buffer_reg;
  logic             hold_full_reg;
  logic             empty_flag_reg;
  logic             irq_en_reg;
  logic [1:0]       flag_delay_reg;
  logic [1:0]       icyc_reg;
  logic [9:0]       tx_shift_register;
  logic [3:0]       bits_left_reg;
  logic [6:0]       tick_cnt_reg;
  logic             shift_empty_reg;
  logic             ack_reg;
  logic             baud_tick;
  logic             port_run;
  logic             bus_write;
  logic             bus_read;
  logic             hold_wr;
  logic             transmit_enable_rise;
  logic [6:0]       bit_ticks;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign port_run  = ctrl_reg[ast_pkg::CS_PORT_ENABLE] && !ctrl_reg[ast_pkg::CS_SYNC_MODE]
                     && !sleep_i;
  assign bus_write = avs_write && !ack_reg;
  assign bus_read  = avs_read && !ack_reg;
  assign hold_wr   = bus_write && avs_address == ast_pkg::ADDR_HOLD_BUF;
  assign transmit_enable_rise = bus_write && avs_address == ast_pkg::ADDR_CTRL_STAT
                     && avs_writedata[ast_pkg::CS_TX_ENABLE] && !ctrl_reg[ast_pkg::CS_TX_ENABLE];
  assign bit_ticks = ctrl_reg[ast_pkg::CS_HIGH_SPEED] ? ast_pkg::OVERSAMPLE_HI
                     : ast_pkg::OVERSAMPLE_LO;

  ast_baud_gen #(.DIV_W(DIV_W)) u_baud_generator (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .run_i     (port_run),
    .divisor_i (baud_divisor_reg),
    .tick_o    (baud_tick)
  );

  // ****************************************************************
  // avalon slave: one wait cycle, answer on second edge
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !ack_reg);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      avs_readdata <= 32'h0000_0000;
    else if (bus_read)
    begin
      unique case (avs_address)
        ast_pkg::ADDR_CTRL_STAT:
          avs_readdata <= {24'h00_0000, ctrl_reg[7:2], shift_empty_reg,
                           ctrl_reg[0]};
        ast_pkg::ADDR_BAUD_DIV:
          avs_readdata <= {24'h00_0000, baud_divisor_reg};
        ast_pkg::ADDR_HOLD_BUF:
          avs_readdata <= {24'h00_0000, tx_holding_buffer_reg};
        ast_pkg::ADDR_FLAGS:
          avs_readdata <= {27'h000_0000, empty_flag_reg, 4'h0};
        ast_pkg::ADDR_IRQ_EN:
          avs_readdata <= {27'h000_0000, irq_en_reg, 4'h0};
        default:
          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      ctrl_reg <= ast_pkg::CTRL_RESET;
    else if (bus_write && avs_address == ast_pkg::ADDR_CTRL_STAT)
      ctrl_reg <= {avs_writedata[7:2], 1'b0, avs_writedata[0]};
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      baud_divisor_reg <= ast_pkg::BAUD_RESET;
    else if (bus_write && avs_address == ast_pkg::ADDR_BAUD_DIV)
      baud_divisor_reg <= avs_writedata[7:0];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      irq_en_reg <= 1'b0;
    else if (bus_write && avs_address == ast_pkg::ADDR_IRQ_EN)
      irq_en_reg <= avs_writedata[ast_pkg::IRQ_TX_EMPTY];
  end

  // instruction cycle is four clocks
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      icyc_reg <= 2'h0;
    else
      icyc_reg <= icyc_reg + 2'h1;
  end

  // ****************************************************************
  // holding buffer and its empty flag
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      tx_holding_buffer_reg <= 8'h00;
    else if (hold_wr)
      tx_holding_buffer_reg <= avs_writedata[7:0];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      hold_full_reg <= 1'b0;
    else if (hold_wr && ctrl_reg[ast_pkg::CS_TX_ENABLE])
      hold_full_reg <= 1'b1;
    else if (state_reg == ST_LOAD && icyc_reg == ast_pkg::INSTR_CYCLE)
      hold_full_reg <= 1'b0;
  end

  // flag drops two instruction cycles after the write lands
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      flag_delay_reg <= 2'h0;
    else if (hold_wr && ctrl_reg[ast_pkg::CS_TX_ENABLE])
      flag_delay_reg <= 2'h2;
    else if (flag_delay_reg != 2'h0 && icyc_reg == ast_pkg::INSTR_CYCLE)
      flag_delay_reg <= flag_delay_reg - 2'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      empty_flag_reg <= 1'b0;
    else if (transmit_enable_rise)
      empty_flag_reg <= 1'b1;
    else if (state_reg == ST_LOAD && icyc_reg == ast_pkg::INSTR_CYCLE)
      empty_flag_reg <= 1'b1;
    else if (flag_delay_reg == 2'h1 && icyc_reg == ast_pkg::INSTR_CYCLE && hold_full_reg)
      empty_flag_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      tx_irq_o <= 1'b0;
    else
      tx_irq_o <= empty_flag_reg && irq_en_reg;
  end

  // ****************************************************************
  // transmit sequencer
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !ctrl_reg[ast_pkg::CS_TX_ENABLE])
    begin
      state_reg         <= ST_IDLE;
      tx_shift_register <= 10'h3ff;
      bits_left_reg     <= 4'h0;
      tick_cnt_reg      <= 7'h00;
      shift_empty_reg   <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          if (hold_full_reg && port_run)
            state_reg <= ST_LOAD;
        ST_LOAD:
          if (icyc_reg == ast_pkg::INSTR_CYCLE)
          begin
            // stop, optional ninth bit, data; start bit comes from start_phase_reg; lsb leaves first
            tx_shift_register <= ctrl_reg[ast_pkg::CS_NINE_BIT]
              ? {1'b1, ctrl_reg[ast_pkg::CS_NINTH_DATA], tx_holding_buffer_reg}
              : {2'b11, tx_holding_buffer_reg};
            bits_left_reg     <= ctrl_reg[ast_pkg::CS_NINE_BIT]
              ? ast_pkg::BITS_9_FRAME : ast_pkg::BITS_8_FRAME;
            tick_cnt_reg      <= 7'h00;
            shift_empty_reg   <= 1'b0;
            state_reg         <= ST_SHIFT;
          end
        ST_SHIFT:
          if (baud_tick)
          begin
            if (tick_cnt_reg == bit_ticks - 7'h01)
            begin
              tick_cnt_reg <= 7'h00;
              if (bits_left_reg == 4'h0)
              begin
                shift_empty_reg <= 1'b1;
                state_reg       <= hold_full_reg ? ST_LOAD : ST_IDLE;
              end
              else
              begin
                // the start period holds the shifter so that data bit zero is sent
                if (!start_phase_reg)
                  tx_shift_register <= {1'b1, tx_shift_register[9:1]};
                bits_left_reg     <= bits_left_reg - 4'h1;
              end
            end
            else
              tick_cnt_reg <= tick_cnt_reg + 7'h01;
          end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // start bit is a zero held in front of the shifter
  logic start_phase_reg;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || !ctrl_reg[ast_pkg::CS_TX_ENABLE])
      start_phase_reg <= 1'b0;
    else if (state_reg == ST_LOAD && icyc_reg == ast_pkg::INSTR_CYCLE)
      start_phase_reg <= 1'b1;
    else if (state_reg == ST_SHIFT && baud_tick && tick_cnt_reg == bit_ticks - 7'h01)
      start_phase_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      tx_o <= 1'b1;
    else if (state_reg != ST_SHIFT)
      tx_o <= 1'b1;
    else if (start_phase_reg)
      tx_o <= 1'b0;
    else
      tx_o <= tx_shift_register[0];
  end
endmodule : ast_transmitter

/* File: verification/ast_transmitter_chk.sv */
// port-level assertions for the serial transmitter
`timescale 1ns/10ps
module ast_transmitter_chk #(
  parameter int DIV_W = 8
) (
  input wire logic        ref_clk_i,
  input wire logic        srst_i,
  input wire logic        sleep_i,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tx_o,
  input wire logic        tx_irq_o
);
  // ****
  // cycles the line has held its level
  // ****
  logic [11:0] seg_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i || $changed(tx_o))
      seg_q <= 12'h000;
    else
      seg_q <= seg_q + 12'h001;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  property p_wait_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low too long");
  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered");
  property p_irq_mask;
    avs_write && !avs_waitrequest && avs_address == ast_pkg::ADDR_IRQ_EN
      && !avs_writedata[4] |-> ##[1:2] !tx_irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq not masked");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > ast_pkg::ADDR_IRQ_EN |-> avs_readdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits set");
  property p_sleep; $past(sleep_i, 2) && $past(sleep_i) && sleep_i |-> $stable(tx_o);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("line moved in sleep");
  property p_bit_len; $rose(tx_o) |-> seg_q[3:0] == 4'hf; endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("low run not whole bits");
  property p_busy;
    avs_read && !avs_waitrequest && avs_address == ast_pkg::ADDR_CTRL_STAT
      && !$past(tx_o) |-> !avs_readdata[1];
  endproperty
  a_busy: assert property (p_busy)
    else $error("shift empty while sending");
  c_frame: cover property ($fell(tx_o));
  c_irq: cover property ($rose(tx_irq_o));
  c_sleep_wr: cover property (sleep_i && avs_write && !avs_waitrequest);
endmodule : ast_transmitter_chk

/* File: verification/ast_rx_model.sv */
// receiving end of the serial line, samples mid-bit
`timescale 1ns/10ps
module ast_rx_model (
  input  wire logic       ref_clk_i,
  input  wire logic       line_i,
  input  wire logic       nine_i,
  input  wire logic [6:0] bit_clks_i,
  output logic [8:0]      data_o,
  output logic            stop_o,
  output logic [7:0]      count_o
);
  logic [8:0] sh;
  int         i;
  initial
  begin
    count_o = 8'h00;
    data_o = 9'h000;
    stop_o = 1'b0;
    forever
    begin
      @(negedge line_i);
      repeat (bit_clks_i / 2) @(posedge ref_clk_i);
      if (line_i === 1'b0)
      begin
        sh = 9'h000;
        for (i = 0; i < (nine_i ? 9 : 8); i++)
        begin
          repeat (bit_clks_i) @(posedge ref_clk_i);
          sh[i] = line_i;
        end
        repeat (bit_clks_i) @(posedge ref_clk_i);
        stop_o = line_i;
        data_o = sh;
        count_o = count_o + 8'h01;
      end
    end
  end
endmodule : ast_rx_model

/* File: verification/ast_transmitter_tb.sv */
// testbench for the serial transmitter
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module ast_transmitter_tb;
  logic        ref_clk_i, srst_i, sleep_i, avs_read, avs_write;
  logic        avs_waitrequest, tx_o, tx_irq_o, rx_stop, rx_nine;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [8:0]  rx_data;
  logic [7:0]  rx_cnt;
  logic [6:0]  rx_bit;
  int          n_fail, checked;
  ast_transmitter dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sleep_i(sleep_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_o(tx_o), .tx_irq_o(tx_irq_o));
  ast_rx_model u_rx (.ref_clk_i(ref_clk_i), .line_i(tx_o), .nine_i(rx_nine),
    .bit_clks_i(rx_bit), .data_o(rx_data), .stop_o(rx_stop), .count_o(rx_cnt));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // ****
  // bus access, serial wait and verdict
  // ****
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge ref_clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wait_rx(input logic [7:0] n, input logic [8:0] exp);
    int k;
    k = 0;
    while (rx_cnt !== n && k < 4000)
    begin
      @(posedge ref_clk_i);
      k++;
    end
    `CHK(rx_data, exp)
    `CHK(rx_stop, 1'b1)
  endtask : wait_rx
  task automatic summarize();
    $display("checks %0d errors %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    summarize();
  end
  initial
  begin
    srst_i = 1'b1;
    sleep_i = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    rx_nine = 1'b0;
    rx_bit = 7'h10;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    bus(1'b0, ast_pkg::ADDR_CTRL_STAT, 8'h00);
    `CHK(rd[7:0], ast_pkg::CTRL_RESET)
    bus(1'b0, ast_pkg::ADDR_FLAGS, 8'h00);
    `CHK(rd[7:0], 8'h00)
    bus(1'b0, 4'hf, 8'h00);
    `CHK(rd, 32'h0000_0000)
    `CHK(tx_o, 1'b1)
    bus(1'b1, ast_pkg::ADDR_BAUD_DIV, 8'h00);
    bus(1'b1, ast_pkg::ADDR_CTRL_STAT, 8'h84);
    bus(1'b1, ast_pkg::ADDR_IRQ_EN, 8'h10);
    bus(1'b0, ast_pkg::ADDR_FLAGS, 8'h00);
    `CHK(rd[7:0], 8'h00)
    bus(1'b1, ast_pkg::ADDR_CTRL_STAT, 8'ha4);
    bus(1'b0, ast_pkg::ADDR_FLAGS, 8'h00);
    `CHK(rd[7:0], 8'h10)
    `CHK(tx_irq_o, 1'b1)
    bus(1'b1, ast_pkg::ADDR_FLAGS, 8'h00);
    bus(1'b0, ast_pkg::ADDR_FLAGS, 8'h00);
    `CHK(rd[7:0], 8'h10)
    bus(1'b1, ast_pkg::ADDR_HOLD_BUF, 8'ha5);
    repeat (8) @(posedge ref_clk_i);
    bus(1'b1, ast_pkg::ADDR_HOLD_BUF, 8'h3c);
    repeat (8) @(posedge ref_clk_i);
    bus(1'b0, ast_pkg::ADDR_FLAGS, 8'h00);
    `CHK(rd[7:0], 8'h00)
    bus(1'b0, ast_pkg::ADDR_CTRL_STAT, 8'h00);
    `CHK(rd[1], 1'b0)
    wait_rx(8'h01, 9'h0a5);
    wait_rx(8'h02, 9'h03c);
    repeat (24) @(posedge ref_clk_i);
    bus(1'b0, ast_pkg::ADDR_CTRL_STAT, 8'h00);
    `CHK(rd[1], 1'b1)
    rx_nine <= 1'b1;
    bus(1'b1, ast_pkg::ADDR_CTRL_STAT, 8'he5);
    bus(1'b1, ast_pkg::ADDR_HOLD_BUF, 8'h5a);
    wait_rx(8'h03, 9'h15a);
    rx_nine <= 1'b0;
    rx_bit <= 7'h40;
    bus(1'b1, ast_pkg::ADDR_CTRL_STAT, 8'ha0);
    bus(1'b1, ast_pkg::ADDR_HOLD_BUF, 8'h81);
    wait_rx(8'h04, 9'h081);
    sleep_i <= 1'b1;
    bus(1'b1, ast_pkg::ADDR_HOLD_BUF, 8'h42);
    repeat (300) @(posedge ref_clk_i);
    `CHK(tx_o, 1'b1)
    sleep_i <= 1'b0;
    wait_rx(8'h05, 9'h042);
    bus(1'b1, ast_pkg::ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    `CHK(tx_irq_o, 1'b0)
    summarize();
  end
endmodule : ast_transmitter_tb
bind ast_transmitter ast_transmitter_chk #(.DIV_W(DIV_W)) u_chk (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .sleep_i(sleep_i), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tx_o(tx_o), .tx_irq_o(tx_irq_o));
